// ==== sim/cdu_ctrl_tb.sv ====
// self-checking bench for the configuration download/update controller
// assumes the host model drives all byte traffic; load delay shortened to 20
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module cdu_ctrl_tb;
    // ************************************************************
    // signals, instances, helpers
    // ************************************************************
    localparam int LD = 20;
    logic ref_clk = 1'b0, arst_n = 1'b0, supply_above_lockout = 1'b0, se_advance = 1'b0;
    logic wr_stb, wr_first, wr_nvm, rd_stb, se_wr_stb, host_ack_en, cfg_xfer_pulse;
    logic [7:0] wr_data, rd_data;
    logic [5:0] se_wr_addr, se_state_index;
    logic [63:0] se_wr_word, se_state_word;
    logic [255:0] cfg_active;
    int error_cnt = 0, check_count = 0;
    logic [31:0] rows [3] = '{32'h00073cff, 32'h0108c3c3, 32'h001f11ff};
    cdu_ctrl #(.LOAD_DELAY_CYC(LD)) cdu_ctrl_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .supply_above_lockout(supply_above_lockout), .wr_stb(wr_stb), .wr_first(wr_first),
        .wr_nvm(wr_nvm), .wr_data(wr_data), .rd_stb(rd_stb), .se_wr_stb(se_wr_stb),
        .se_wr_addr(se_wr_addr), .se_wr_word(se_wr_word), .se_advance(se_advance),
        .host_ack_en(host_ack_en), .rd_data(rd_data), .cfg_active(cfg_active),
        .cfg_xfer_pulse(cfg_xfer_pulse), .se_state_word(se_state_word),
        .se_state_index(se_state_index));
    cdu_host cdu_host_inst (.ref_clk(ref_clk), .wr_stb(wr_stb), .wr_first(wr_first),
        .wr_nvm(wr_nvm), .wr_data(wr_data), .rd_stb(rd_stb), .se_wr_stb(se_wr_stb),
        .se_wr_addr(se_wr_addr), .se_wr_word(se_wr_word));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] item(input logic [7:0] i);
        return cfg_active[8*i+:8];
    endfunction
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // bounded wait for the all-latch pulse, then one edge for the bank to land;
    // align to a falling edge first, a commit pulse may already stand on entry
    task automatic wait_xfer;
        int n;
        n = 0;
        @(negedge ref_clk);
        while (cfg_xfer_pulse !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("xfer pulse", 1'b1, cfg_xfer_pulse)
        @(negedge ref_clk);
        `CHK("pulse width", 1'b0, cfg_xfer_pulse)
    endtask
    // watchdog well beyond the ~2400 cycles the run needs
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [7:0] c, a, d, e;
        int n;
        repeat (16) @(posedge ref_clk);
        `CHK("ack in reset", 1'b0, host_ack_en)
        #1 arst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        `CHK("ack no supply", 1'b0, host_ack_en)
        @(posedge ref_clk) #1 supply_above_lockout = 1'b1;
        wait_xfer();
        `CHK("ack at xfer", 1'b0, host_ack_en)
        for (n = 1; n < 60 && host_ack_en !== 1'b1; n++) @(negedge ref_clk);
        `CHK("load delay", 1'b1, n >= LD && n <= LD + 5)
        `CHK("first state", 6'h00, se_state_index)
        // erase enabled, reload shows an all-ones page
        cdu_host_inst.wr_reg(8'h90, 8'h04, 1'b0);
        cdu_host_inst.put(1'b1, 1'b0, 8'hfe);
        repeat (40) @(posedge ref_clk);
        cdu_host_inst.wr_reg(8'hd8, 8'h01, 1'b0);
        wait_xfer();
        `CHK("erased bank", {256{1'b1}}, cfg_active)
        cdu_host_inst.wr_reg(8'h03, 8'h5a, 1'b1);
        repeat (3) @(negedge ref_clk);
        `CHK("nvm staged", 8'hff, item(8'h03))
        // erase disabled: command ignored, reload keeps the nvm byte
        cdu_host_inst.wr_reg(8'h90, 8'h00, 1'b0);
        cdu_host_inst.put(1'b1, 1'b0, 8'hfe);
        repeat (40) @(posedge ref_clk);
        cdu_host_inst.wr_reg(8'hd8, 8'h01, 1'b0);
        wait_xfer();
        `CHK("reload item", 8'h5a, item(8'h03))
        // rows: control value, item, data, expected active value
        foreach (rows[i]) begin
            {c, a, d, e} = rows[i];
            cdu_host_inst.wr_reg(8'h90, c, 1'b0);
            cdu_host_inst.wr_reg(a, d, 1'b0);
            repeat (3) @(negedge ref_clk);
            `CHK("active item", e, item(a))
            cdu_host_inst.rd_reg(a);
            @(negedge ref_clk);
            `CHK("first stage", d, rd_data)
        end
        cdu_host_inst.wr_reg(8'h90, 8'h02, 1'b0);
        wait_xfer();
        `CHK("commit a", 8'h3c, item(8'h07))
        `CHK("commit b", 8'h11, item(8'h1f))
        cdu_host_inst.rd_reg(8'h90);
        @(negedge ref_clk);
        `CHK("commit clears", 8'h00, rd_data)
        // sequencer fetch takes 2000 cycles
        cdu_host_inst.se_put(6'h01, 64'h0123456789abcdef);
        @(posedge ref_clk) #1 se_advance = 1'b1;
        @(posedge ref_clk) #1 se_advance = 1'b0;
        repeat (1900) @(negedge ref_clk);
        `CHK("fetch early", 6'h00, se_state_index)
        for (n = 0; n < 200 && se_state_index !== 6'h01; n++) @(negedge ref_clk);
        // slot index leads the word by the read and take cycles
        repeat (2) @(negedge ref_clk);
        `CHK("next slot", 6'h01, se_state_index)
        `CHK("next word", 64'h0123456789abcdef, se_state_word)
        // second reset in mid-run
        @(posedge ref_clk) #1 arst_n = 1'b0;
        #1;
        `CHK("ack reset", 1'b0, host_ack_en)
        `CHK("bank reset", 256'h0, cfg_active)
        stop_test();
    end
endmodule

// ==== sim/cdu_host.sv ====
// host model: byte strobes from the serial front end plus sequencer word writes
// assumes one clock; drives 1 ns after each rising edge of ref_clk
`timescale 1ns/1ps
module cdu_host (
    input  wire logic                      ref_clk,
    output logic                           wr_stb,
    output logic                           wr_first,
    output logic                           wr_nvm,
    output logic [7:0]                     wr_data,
    output logic                           rd_stb,
    output logic                           se_wr_stb,
    output logic [cdu_pkg::SE_AW-1:0]      se_wr_addr,
    output logic [cdu_pkg::SE_W-1:0]       se_wr_word
);
    // ************************************************************
    // bus tasks
    // ************************************************************
    initial begin
        {wr_stb, wr_first, wr_nvm, wr_data, rd_stb} = '0;
        {se_wr_stb, se_wr_addr, se_wr_word} = '0;
    end
    // one byte strobe; released data shows the inverse, not a stale copy
    task automatic put(input logic f, input logic n, input logic [7:0] d);
        @(posedge ref_clk) #1;
        {wr_stb, wr_first, wr_nvm, wr_data} = {1'b1, f, n, d};
        @(posedge ref_clk) #1;
        {wr_stb, wr_first, wr_nvm, wr_data} = {3'b000, ~d};
    endtask
    // pointer byte always leads a write
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic n);
        put(1'b1, 1'b0, a);
        put(1'b0, n, d);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        put(1'b1, 1'b0, a);
        @(posedge ref_clk) #1;
        rd_stb = 1'b1;
        @(posedge ref_clk) #1;
        rd_stb = 1'b0;
    endtask
    // states change only as whole words in the store
    task automatic se_put(input logic [5:0] s, input logic [63:0] w);
        @(posedge ref_clk) #1;
        {se_wr_stb, se_wr_addr, se_wr_word} = {1'b1, s, w};
        @(posedge ref_clk) #1;
        {se_wr_stb, se_wr_addr, se_wr_word} = {1'b0, ~s, ~w};
    endtask
endmodule

// ==== src/cdu_ctrl.sv ====
// configuration download and update controller with sequencer state loading
// assumes an external serial front end that decodes bus framing into byte strobes
//
// Summary of operation
// - supply above lockout level starts the nonvolatile-to-latch copy
// - power-up copy fills first-stage latches only, second stage untouched
// - after copy, all first-stage latches move to second stage at once
// - first sequencer state loads a fixed delay after power-up configuration load
// - every bus access is refused until the power-up load ends
// - each item has two latches; first stage loads before the second
// - transparent bit set: register writes reach first stage, then second stage one cycle later
// - transparent bit clear: writes change first stage only
// - host writes commit bit; one pulse copies all first stages over
// - nonvolatile writes leave running configuration alone until reload
// - reload command recopies nonvolatile configuration, replacing writes
// - erase command sets page bytes to ones only when erase enabled
// - sequencer store holds 63 usable 64-bit states, one slot reserved
// - met state conditions fetch next state word, taking about 10 us
// - first byte of each write is stored as register address pointer
// - erase enable is bit 2 at 0x90; command 0xfe needs it
// - bit 0 of reload register at 0xd8 recopies configuration
`timescale 1ns/1ps
module cdu_ctrl #(
    parameter int LOAD_DELAY_CYC = cdu_pkg::SE_LOAD_DELAY_CYC
) (
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    input  wire logic                          supply_above_lockout,
    input  wire logic                          wr_stb,
    input  wire logic                          wr_first,
    input  wire logic                          wr_nvm,
    input  wire logic [7:0]                    wr_data,
    input  wire logic                          rd_stb,
    input  wire logic                          se_wr_stb,
    input  wire logic [cdu_pkg::SE_AW-1:0]     se_wr_addr,
    input  wire logic [cdu_pkg::SE_W-1:0]      se_wr_word,
    input  wire logic                          se_advance,
    output logic                               host_ack_en,
    output logic [7:0]                         rd_data,
    output logic [cdu_pkg::CFG_DEPTH*8-1:0]    cfg_active,
    output logic                               cfg_xfer_pulse,
    output logic [cdu_pkg::SE_W-1:0]           se_state_word,
    output logic [cdu_pkg::SE_AW-1:0]          se_state_index
);
    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        cdu_pkg::cdu_fsm_t                     fsm;
        logic [5:0]                            idx;
        logic [5:0]                            cidx;
        logic                                  rd_pend;
        logic [cdu_pkg::CNT_W-1:0]             cnt;
        logic [cdu_pkg::CFG_DEPTH-1:0][7:0]    a;
        logic [cdu_pkg::CFG_DEPTH-1:0][7:0]    b;
        logic [7:0]                            ptr;
        logic                                  transp;
        logic                                  erase_en;
        logic                                  reload;
        logic                                  loaded;
        logic                                  pass_pend;
        logic [cdu_pkg::CFG_AW-1:0]            pass_idx;
        logic                                  xfer;
        logic [7:0]                            rd;
        logic [cdu_pkg::SE_AW-1:0]             se_addr;
        logic [cdu_pkg::SE_W-1:0]              se_word;
        logic                                  se_valid;
    } cdu_state_t;

    cdu_state_t                   st_ff;
    cdu_state_t                   nxt_st;
    logic                         cfg_we;
    logic [cdu_pkg::CFG_AW-1:0]   cfg_waddr;
    logic [7:0]                   cfg_wdata;
    logic [7:0]                   cfg_rdata;
    logic [cdu_pkg::SE_W-1:0]     se_rdata;
    logic                         acc_ok;
    logic                         item_wr;
    logic                         erase_cmd;

    // ************************************************************
    // nonvolatile stores
    // ************************************************************
    // configuration page copied into the first-stage latches
    cdu_mem #(
        .W  (8),
        .D  (cdu_pkg::CFG_DEPTH),
        .AW (cdu_pkg::CFG_AW)
    ) u_cfg_nvm (
        .clk      (ref_clk),
        .we       (cfg_we),
        .waddr    (cfg_waddr),
        .wdata    (cfg_wdata),
        .raddr    (st_ff.idx[cdu_pkg::CFG_AW-1:0]),
        .rdata_ff (cfg_rdata)
    );

    // sequencer state words; whole-word writes only, no volatile copy
    cdu_mem #(
        .W  (cdu_pkg::SE_W),
        .D  (cdu_pkg::SE_DEPTH),
        .AW (cdu_pkg::SE_AW)
    ) u_se_nvm (
        .clk      (ref_clk),
        .we       (se_wr_stb),
        .waddr    (se_wr_addr),
        .wdata    (se_wr_word),
        .raddr    (st_ff.se_addr),
        .rdata_ff (se_rdata)
    );

    // ************************************************************
    // access decode
    // ************************************************************
    // accesses only count once loaded and in run or sequencer fetch wait; others are refused
    assign acc_ok    = st_ff.loaded && (st_ff.fsm == cdu_pkg::CDU_RUN
                       || st_ff.fsm == cdu_pkg::CDU_SE_WAIT);
    assign item_wr   = acc_ok && wr_stb && !wr_first && !wr_nvm
                       && (st_ff.ptr < 8'(cdu_pkg::CFG_DEPTH));
    assign erase_cmd = acc_ok && wr_stb && wr_first && (wr_data == cdu_pkg::ERASE_CMD);

    // nonvolatile write port: erase walk or staged host byte
    always_comb begin
        cfg_we    = 1'b0;
        cfg_waddr = st_ff.ptr[cdu_pkg::CFG_AW-1:0];
        cfg_wdata = wr_data;
        if (st_ff.fsm == cdu_pkg::CDU_ERASE) begin
            cfg_we    = 1'b1;
            cfg_waddr = st_ff.idx[cdu_pkg::CFG_AW-1:0];
            cfg_wdata = cdu_pkg::ERASED_BYTE;
        end else if (acc_ok && wr_stb && !wr_first && wr_nvm
                     && st_ff.ptr < 8'(cdu_pkg::CFG_DEPTH)) begin
            cfg_we = 1'b1;
        end
    end

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.xfer = 1'b0;
        nxt_st.pass_pend = 1'b0;

        // second stage of a transparent write follows one cycle later
        if (st_ff.pass_pend) begin
            nxt_st.b[st_ff.pass_idx] = st_ff.a[st_ff.pass_idx];
        end

        // pointer and register writes
        if (acc_ok && wr_stb && wr_first) begin
            nxt_st.ptr = wr_data;
        end
        if (item_wr) begin
            nxt_st.a[st_ff.ptr[cdu_pkg::CFG_AW-1:0]] = wr_data;
            if (st_ff.transp) begin
                nxt_st.pass_pend = 1'b1;
                nxt_st.pass_idx  = st_ff.ptr[cdu_pkg::CFG_AW-1:0];
            end
        end
        if (acc_ok && wr_stb && !wr_first && !wr_nvm && st_ff.ptr == cdu_pkg::REG_UPD_CTRL) begin
            nxt_st.transp   = wr_data[cdu_pkg::UPD_TRANSP_BIT];
            nxt_st.erase_en = wr_data[cdu_pkg::UPD_ERASE_BIT];
            nxt_st.xfer     = wr_data[cdu_pkg::UPD_COMMIT_BIT];
        end

        // register reads; commit bit always reads zero
        if (acc_ok && rd_stb) begin
            if (st_ff.ptr < 8'(cdu_pkg::CFG_DEPTH)) begin
                nxt_st.rd = st_ff.a[st_ff.ptr[cdu_pkg::CFG_AW-1:0]];
            end else if (st_ff.ptr == cdu_pkg::REG_UPD_CTRL) begin
                nxt_st.rd = 8'h00;
                nxt_st.rd[cdu_pkg::UPD_TRANSP_BIT] = st_ff.transp;
                nxt_st.rd[cdu_pkg::UPD_ERASE_BIT]  = st_ff.erase_en;
            end else begin
                nxt_st.rd = 8'h00;
            end
        end

        // one-cycle pulse moves every first stage across together
        if (st_ff.xfer) begin
            nxt_st.b = st_ff.a;
        end

        case (st_ff.fsm)
            cdu_pkg::CDU_WAIT_SUPPLY: begin
                if (supply_above_lockout) begin
                    nxt_st.fsm     = cdu_pkg::CDU_COPY;
                    nxt_st.idx     = 6'h00;
                    nxt_st.rd_pend = 1'b0;
                    nxt_st.reload  = 1'b0;
                end
            end
            cdu_pkg::CDU_COPY: begin
                // read issued one cycle, stored into first stage the next
                nxt_st.rd_pend = (st_ff.idx != cdu_pkg::CFG_IDX_END);
                nxt_st.cidx    = st_ff.idx;
                if (st_ff.idx != cdu_pkg::CFG_IDX_END) begin
                    nxt_st.idx = st_ff.idx + 6'h01;
                end
                if (st_ff.rd_pend) begin
                    nxt_st.a[st_ff.cidx[cdu_pkg::CFG_AW-1:0]] = cfg_rdata;
                end
                if (st_ff.rd_pend && st_ff.idx == cdu_pkg::CFG_IDX_END) begin
                    nxt_st.fsm = cdu_pkg::CDU_XFER;
                end
            end
            cdu_pkg::CDU_XFER: begin
                // all second stages take the downloaded data at once
                nxt_st.xfer = 1'b1;
                nxt_st.cnt  = '0;
                nxt_st.fsm  = st_ff.reload ? cdu_pkg::CDU_RUN : cdu_pkg::CDU_DELAY;
            end
            cdu_pkg::CDU_DELAY: begin
                // wait before the first sequencer state is fetched
                nxt_st.cnt = st_ff.cnt + 1'b1;
                if (st_ff.cnt == cdu_pkg::CNT_W'(LOAD_DELAY_CYC - 1)) begin
                    nxt_st.fsm     = cdu_pkg::CDU_SE_LOAD;
                    nxt_st.se_addr = cdu_pkg::SE_FIRST_STATE;
                end
            end
            cdu_pkg::CDU_SE_LOAD: begin
                nxt_st.fsm = cdu_pkg::CDU_SE_TAKE;
            end
            cdu_pkg::CDU_SE_TAKE: begin
                // only now is the part open to the bus
                nxt_st.se_word  = se_rdata;
                nxt_st.se_valid = 1'b1;
                nxt_st.loaded   = 1'b1;
                nxt_st.fsm      = cdu_pkg::CDU_RUN;
            end
            cdu_pkg::CDU_RUN: begin
                if (acc_ok && wr_stb && !wr_first && !wr_nvm
                    && st_ff.ptr == cdu_pkg::REG_USER_RELOAD && wr_data[cdu_pkg::RELOAD_BIT]) begin
                    nxt_st.fsm     = cdu_pkg::CDU_COPY;
                    nxt_st.idx     = 6'h00;
                    nxt_st.rd_pend = 1'b0;
                    nxt_st.reload  = 1'b1;
                end else if (erase_cmd && st_ff.erase_en) begin
                    nxt_st.fsm = cdu_pkg::CDU_ERASE;
                    nxt_st.idx = 6'h00;
                end else if (se_advance) begin
                    nxt_st.fsm = cdu_pkg::CDU_SE_WAIT;
                    nxt_st.cnt = '0;
                end
            end
            cdu_pkg::CDU_SE_WAIT: begin
                // fetch time of the next state word
                nxt_st.cnt = st_ff.cnt + 1'b1;
                if (st_ff.cnt == cdu_pkg::CNT_W'(cdu_pkg::SE_FETCH_CYC - 1)) begin
                    nxt_st.fsm     = cdu_pkg::CDU_SE_LOAD;
                    nxt_st.se_addr = (st_ff.se_addr == cdu_pkg::SE_LAST_STATE)
                                     ? cdu_pkg::SE_FIRST_STATE
                                     : st_ff.se_addr + 6'h01;
                end
            end
            cdu_pkg::CDU_ERASE: begin
                // whole page walks to all ones, one byte per cycle
                nxt_st.idx = st_ff.idx + 6'h01;
                if (st_ff.idx == cdu_pkg::CFG_IDX_END - 6'h01) begin
                    nxt_st.fsm = cdu_pkg::CDU_RUN;
                end
            end
            default: begin
                nxt_st.fsm = cdu_pkg::CDU_WAIT_SUPPLY;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    // latch contents start at zero; real values arrive from the copy
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff          <= '0;
            st_ff.fsm      <= cdu_pkg::CDU_WAIT_SUPPLY;
            st_ff.transp   <= cdu_pkg::UPD_TRANSP_RST;
            st_ff.erase_en <= cdu_pkg::UPD_ERASE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign host_ack_en    = st_ff.loaded;
    assign rd_data        = st_ff.rd;
    assign cfg_active     = st_ff.b;
    assign cfg_xfer_pulse = st_ff.xfer;
    assign se_state_word  = st_ff.se_word;
    assign se_state_index = st_ff.se_addr;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence copy_start_s;
        st_ff.fsm == cdu_pkg::CDU_WAIT_SUPPLY && supply_above_lockout;
    endsequence
    sequence copy_run_s;
        st_ff.fsm == cdu_pkg::CDU_COPY [*8];
    endsequence

    lockout_start_a: assert property (copy_start_s |=> copy_run_s)
        else $error("copy did not start after supply rose");
    copy_holds_b_a: assert property (
        (st_ff.fsm == cdu_pkg::CDU_COPY && !st_ff.reload && !st_ff.xfer) |=> $stable(cfg_active))
        else $error("second stage changed during power-up copy");
    // case equality: an unprogrammed store hands unknown bytes to the power-up copy
    xfer_all_a: assert property (cfg_xfer_pulse |=> cfg_active === $past(st_ff.a))
        else $error("transfer pulse did not copy all first stages");
    no_early_ack_a: assert property (!st_ff.se_valid |-> !host_ack_en)
        else $error("bus acknowledged before load finished");
    se_delay_a: assert property (
        (st_ff.fsm == cdu_pkg::CDU_SE_LOAD && $past(st_ff.fsm) == cdu_pkg::CDU_DELAY)
        |-> $past(st_ff.cnt) == cdu_pkg::CNT_W'(LOAD_DELAY_CYC - 1))
        else $error("first state loaded at wrong delay");
    transparent_a: assert property (
        (item_wr && st_ff.transp) |=> ##1 st_ff.b[$past(st_ff.ptr[4:0], 2)] == $past(wr_data, 2))
        else $error("transparent write did not reach second stage");
    staged_write_a: assert property (
        (item_wr && !st_ff.transp && !st_ff.pass_pend && !st_ff.xfer) |=> $stable(cfg_active))
        else $error("staged write changed active configuration");
    commit_pulse_a: assert property (cfg_xfer_pulse |=> !cfg_xfer_pulse)
        else $error("commit pulse longer than one cycle");
    nvm_staged_a: assert property (
        (cfg_we && st_ff.fsm == cdu_pkg::CDU_RUN && !st_ff.pass_pend && !st_ff.xfer)
        |=> $stable(cfg_active))
        else $error("nonvolatile write changed active configuration");
    erase_gate_a: assert property (
        (erase_cmd && !st_ff.erase_en) |=> st_ff.fsm != cdu_pkg::CDU_ERASE)
        else $error("erase ran while disabled");
    reload_start_a: assert property (
        (item_wr == 1'b0 && acc_ok && wr_stb && !wr_first && !wr_nvm
         && st_ff.ptr == cdu_pkg::REG_USER_RELOAD && wr_data[0]
         && st_ff.fsm == cdu_pkg::CDU_RUN) |=> st_ff.fsm == cdu_pkg::CDU_COPY && st_ff.reload)
        else $error("reload command did not start copy");
    pointer_load_a: assert property (
        (acc_ok && wr_stb && wr_first) |=> st_ff.ptr == $past(wr_data))
        else $error("address pointer not loaded");
    se_range_a: assert property (se_state_index <= cdu_pkg::SE_LAST_STATE)
        else $error("reserved sequencer slot addressed");
endmodule

// ==== src/cdu_mem.sv ====
// small memory with one write port and one registered read port
// assumes contents need no reset; nonvolatile data is kept by the array
`timescale 1ns/1ps
module cdu_mem #(
    parameter int W  = 8,
    parameter int D  = 32,
    parameter int AW = 5
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata_ff
);
    logic [W-1:0] mem [D];

    // ************************************************************
    // storage and read register
    // ************************************************************
    // read data lags the address by one edge
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end
endmodule

// ==== src/cdu_pkg.sv ====
// constants and enumerations for the configuration download/update block
// assumes a 200 MHz internal clock and a byte-wide register front end
package cdu_pkg;
    // ************************************************************
    // sizes of latch banks and nonvolatile stores
    // ************************************************************
    localparam int          CFG_DEPTH      = 32;
    localparam int          CFG_AW         = 5;
    localparam int          SE_DEPTH       = 64;
    localparam int          SE_AW          = 6;
    localparam int          SE_W           = 64;
    localparam logic [5:0]  SE_LAST_STATE  = 6'h3e;   // slot 63 is reserved
    localparam logic [5:0]  SE_FIRST_STATE = 6'h00;
    localparam logic [5:0]  CFG_IDX_END    = 6'h20;

    // ************************************************************
    // register map and field positions
    // ************************************************************
    localparam logic [7:0]  REG_UPD_CTRL    = 8'h90;
    localparam logic [7:0]  REG_USER_RELOAD = 8'hd8;
    localparam logic [7:0]  ERASE_CMD       = 8'hfe;
    localparam logic [7:0]  ERASED_BYTE     = 8'hff;
    localparam int          UPD_TRANSP_BIT  = 0;
    localparam int          UPD_COMMIT_BIT  = 1;
    localparam int          UPD_ERASE_BIT   = 2;
    localparam int          RELOAD_BIT      = 0;
    localparam logic        UPD_TRANSP_RST  = 1'b0;
    localparam logic        UPD_ERASE_RST   = 1'b0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          SE_LOAD_DELAY_NS = 500000;
    localparam int          SE_FETCH_NS      = 10000;
    localparam int          SE_LOAD_DELAY_CYC = (SE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
    localparam int          SE_FETCH_CYC     = SE_FETCH_NS / CLK_PERIOD_NS;
    localparam int          CNT_W            = 17;

    // ************************************************************
    // controller states
    // ************************************************************
    typedef enum logic [3:0] {
        CDU_WAIT_SUPPLY,
        CDU_COPY,
        CDU_XFER,
        CDU_DELAY,
        CDU_SE_LOAD,
        CDU_SE_TAKE,
        CDU_RUN,
        CDU_SE_WAIT,
        CDU_ERASE
    } cdu_fsm_t;
endpackage
